// file: pcic_top.v
// PLL configuration register and clock interrupt logic with AXI4-Lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pcic_map.vh"

module pcic_top #(
	parameter ADDR_W = 8,
	parameter NSYNC  = 7
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              pll_on,
	input  wire              internal_fast_osc_on,
	input  wire              pll_locked,
	input  wire              internal_16mhz_osc_ready,
	input  wire              external_fast_osc_ready,
	input  wire              external_slow_osc_ready,
	input  wire              internal_slow_osc_ready,
	input  wire              external_fast_osc_fail,
	input  wire              external_slow_osc_fail,
	output wire [4:0]        vco_div_p,
	output wire [5:0]        p_divide_ratio,
	output wire              p_ratio_valid,
	output wire              p_output_enable,
	output wire [6:0]        feedback_multiplier,
	output wire              feedback_valid,
	output wire [3:0]        input_divide_ratio,
	output wire [1:0]        loop_input_select,
	output wire              src_internal_sel,
	output wire              src_external_sel,
	output wire              clock_irq
);

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
function is_word;
	input [7:0] word;
	input [7:0] ofs;
	begin
		is_word = (word == ofs);
	end
endfunction

function mapped;
	input [ADDR_W-1:0] a;
	reg   [7:0]        w;
	begin
		w = {a[7:2], 2'b00};
		mapped = is_word(w, `PCIC_OFS_PLLCFG) || is_word(w, `PCIC_OFS_IRQEN) ||
			is_word(w, `PCIC_OFS_FLAGS) || is_word(w, `PCIC_OFS_CLEAR);
	end
endfunction

function [31:0] strb_mask;
	input [3:0] s;
	begin
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	end
endfunction

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [31:0]       cfg_q;
reg  [31:0]       cfg_d;
reg  [31:0]       ien_q;
reg  [31:0]       ien_d;
reg  [31:0]       flg_q;
reg  [31:0]       flg_d;
reg  [31:0]       set_w;
reg  [31:0]       clr_w;

reg               aw_got_q;
reg  [ADDR_W-1:0] aw_addr_q;
reg               w_got_q;
reg  [31:0]       w_data_q;
reg  [3:0]        w_strb_q;
reg               bvalid_q;
reg  [1:0]        bresp_q;
reg               rvalid_q;
reg  [1:0]        rresp_q;
reg  [31:0]       rdata_q;

wire              wr_go;
wire [7:0]        wr_word;
wire [31:0]       wmask;
wire [7:0]        rd_word;
wire              wr_cfg;
wire              wr_ien;
wire              wr_clr;
wire              rd_go;
reg  [31:0]       rdata_d;

// ----------------------------------------------------------------
// Write channels
// ----------------------------------------------------------------
// Address and data latched separately; either may come first
assign s_axi_awready = !aw_got_q && !bvalid_q;
assign s_axi_wready  = !w_got_q && !bvalid_q;
assign wr_go         = aw_got_q && w_got_q && !bvalid_q;
assign wr_word       = {aw_addr_q[7:2], 2'b00};
assign wmask         = strb_mask(w_strb_q);
assign s_axi_bvalid  = bvalid_q;
assign s_axi_bresp   = bresp_q;
// A write to the flags register is answered but changes nothing
assign wr_cfg        = wr_go && is_word(wr_word, `PCIC_OFS_PLLCFG);
assign wr_ien        = wr_go && is_word(wr_word, `PCIC_OFS_IRQEN);
assign wr_clr        = wr_go && is_word(wr_word, `PCIC_OFS_CLEAR);

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_got_q  <= 1'b0;
		aw_addr_q <= {ADDR_W{1'b0}};
		w_got_q   <= 1'b0;
		w_data_q  <= 32'h00000000;
		w_strb_q  <= 4'h0;
		bvalid_q  <= 1'b0;
		bresp_q   <= `PCIC_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q  <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_q  <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		if (wr_go) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q  <= mapped(aw_addr_q) ? `PCIC_RESP_OKAY : `PCIC_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// Read channel
// ----------------------------------------------------------------
assign s_axi_arready = !rvalid_q;
assign s_axi_rvalid  = rvalid_q;
assign s_axi_rresp   = rresp_q;
assign s_axi_rdata   = rdata_q;
assign rd_word       = {s_axi_araddr[7:2], 2'b00};
assign rd_go         = s_axi_arvalid && s_axi_arready;

// Mux is combinational; the data flop holds the word for the whole beat
always @* begin
	case (rd_word)
	`PCIC_OFS_PLLCFG: rdata_d = cfg_q;
	`PCIC_OFS_IRQEN:  rdata_d = ien_q;
	`PCIC_OFS_FLAGS:  rdata_d = flg_q;
	// Clear register is write-only and reads back zero
	default:          rdata_d = 32'h00000000;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		rvalid_q <= 1'b0;
		rresp_q  <= `PCIC_RESP_OKAY;
		rdata_q  <= 32'h00000000;
	end else if (rd_go) begin
		rvalid_q <= 1'b1;
		rresp_q  <= mapped(s_axi_araddr) ? `PCIC_RESP_OKAY : `PCIC_RESP_SLVERR;
		rdata_q  <= rdata_d;
	end else if (rvalid_q && s_axi_rready) begin
		rvalid_q <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Status input synchronisers
// ----------------------------------------------------------------
// Oscillator status comes from other clock trees: three stages
wire [NSYNC-1:0] raw_w;
reg  [NSYNC-1:0] s1_q;
reg  [NSYNC-1:0] s2_q;
reg  [NSYNC-1:0] s3_q;
reg  [NSYNC-1:0] stab_q;
wire [NSYNC-1:0] rise_w;

assign raw_w = {external_slow_osc_fail, external_fast_osc_fail, pll_locked,
	external_fast_osc_ready, internal_16mhz_osc_ready,
	external_slow_osc_ready, internal_slow_osc_ready};

genvar gi;
generate
	for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
		always @(posedge aclk) begin
			if (!aresetn) begin
				s1_q[gi]   <= 1'b0;
				s2_q[gi]   <= 1'b0;
				s3_q[gi]   <= 1'b0;
				stab_q[gi] <= 1'b0;
			end else begin
				s1_q[gi] <= raw_w[gi];
				s2_q[gi] <= s1_q[gi];
				s3_q[gi] <= s2_q[gi];
				if (s2_q[gi] == s3_q[gi])
					stab_q[gi] <= s3_q[gi];
			end
		end
		// A new level counts once the last two stages agree
		assign rise_w[gi] = s2_q[gi] && s3_q[gi] && !stab_q[gi];
	end
endgenerate

// ----------------------------------------------------------------
// Flag set and clear
// ----------------------------------------------------------------
always @* begin
	set_w = 32'h00000000;
	set_w[`PCIC_B_ISLOW] = rise_w[0] && ien_q[`PCIC_B_ISLOW]; // R12
	set_w[`PCIC_B_ESLOW] = rise_w[1] && ien_q[`PCIC_B_ESLOW]; // R12
	// Requests from peripherals alone never raise this flag
	set_w[`PCIC_B_IFAST] = rise_w[2] && ien_q[`PCIC_B_IFAST] &&
		internal_fast_osc_on; // R11
	set_w[`PCIC_B_EFAST] = rise_w[3] && ien_q[`PCIC_B_EFAST]; // R10
	set_w[`PCIC_B_LOCK]  = rise_w[4] && ien_q[`PCIC_B_LOCK]; // R9
	set_w[`PCIC_B_EFAIL] = rise_w[5]; // R14
	set_w[`PCIC_B_SFAIL] = rise_w[6]; // R13
end

always @* begin
	clr_w = 32'h00000000;
	if (wr_clr)
		clr_w = w_data_q & wmask & `PCIC_MSK_FLAGS; // R15
end

always @* begin
	// Set beats clear so an event in the clear cycle survives
	flg_d = ((flg_q & ~clr_w) | set_w) & `PCIC_MSK_FLAGS; // R15
	ien_d = ien_q;
	if (wr_ien)
		ien_d = (ien_q & ~wmask) | (w_data_q & wmask & `PCIC_MSK_IRQEN); // R8
end

// ----------------------------------------------------------------
// PLL configuration write with lock
// ----------------------------------------------------------------
always @* begin
	cfg_d = cfg_q;
	if (wr_cfg) begin
		// Enable bit stays writable; divider fields freeze while running
		cfg_d = (cfg_q & ~(wmask & `PCIC_MSK_PEN)) |
			(w_data_q & wmask & `PCIC_MSK_PEN); // R3
		if (!pll_on)
			cfg_d = (cfg_d & ~(wmask & `PCIC_MSK_LOCKED)) |
				(w_data_q & wmask & `PCIC_MSK_LOCKED); // R2
	end
end

// Reset value selects a feedback ratio of sixteen
always @(posedge aclk) begin
	if (!aresetn) begin
		cfg_q <= `PCIC_RST_PLLCFG;
	end else begin
		cfg_q <= cfg_d;
	end
end

// Reserved enable bits are masked off on write
always @(posedge aclk) begin
	if (!aresetn) begin
		ien_q <= `PCIC_RST_IRQ; // R16
	end else begin
		ien_q <= ien_d;
	end
end

// Flags hold until cleared; reset is the only other way out
always @(posedge aclk) begin
	if (!aresetn) begin
		flg_q <= `PCIC_RST_IRQ; // R16
	end else begin
		flg_q <= flg_d;
	end
end

// ----------------------------------------------------------------
// Decoded PLL controls
// ----------------------------------------------------------------
wire [4:0] p_code   = cfg_q[`PCIC_P_MSB:`PCIC_P_LSB];
wire [6:0] n_code   = cfg_q[`PCIC_N_MSB:`PCIC_N_LSB];
wire [2:0] m_code   = cfg_q[`PCIC_M_MSB:`PCIC_M_LSB];
wire [1:0] src_code = cfg_q[`PCIC_SRC_MSB:`PCIC_SRC_LSB];

reg  [4:0] p_code_q;
reg  [5:0] p_ratio_q;
reg        p_ok_q;
reg        pen_q;
reg  [6:0] n_q;
reg        n_ok_q;
reg  [3:0] m_ratio_q;
reg  [1:0] src_q;
reg        src_int_q;
reg        src_ext_q;
reg        irq_q;

// Outputs trail the register by one cycle to stay registered
always @(posedge aclk) begin
	if (!aresetn) begin
		p_code_q  <= 5'h00;
		p_ratio_q <= 6'h00;
		p_ok_q    <= 1'b0;
		pen_q     <= 1'b0;
		n_q       <= 7'h00;
		n_ok_q    <= 1'b0;
		m_ratio_q <= 4'h0;
		src_q     <= `PCIC_SRC_NONE;
		src_int_q <= 1'b0;
		src_ext_q <= 1'b0;
	end else begin
		p_code_q  <= p_code;
		p_ratio_q <= {1'b0, p_code} + 6'h01; // R1
		p_ok_q    <= (p_code != 5'h00); // R1
		pen_q     <= cfg_q[`PCIC_PEN_BIT]; // R3
		n_q       <= n_code; // R4
		n_ok_q    <= (n_code >= `PCIC_N_MIN) && (n_code <= `PCIC_N_MAX); // R4
		m_ratio_q <= {1'b0, m_code} + 4'h1; // R5
		src_q     <= src_code; // R6
		src_int_q <= (src_code == `PCIC_SRC_INT); // R6
		src_ext_q <= (src_code == `PCIC_SRC_EXT); // R6
	end
end

// ----------------------------------------------------------------
// Interrupt output
// ----------------------------------------------------------------
// Taken from the next flag value so the pin and the flags move together
always @(posedge aclk) begin
	if (!aresetn) begin
		irq_q <= 1'b0;
	end else begin
		irq_q <= |flg_d; // R18
	end
end

assign vco_div_p           = p_code_q;
assign p_divide_ratio      = p_ratio_q;
assign p_ratio_valid       = p_ok_q;
assign p_output_enable     = pen_q;
assign feedback_multiplier = n_q;
assign feedback_valid      = n_ok_q;
assign input_divide_ratio  = m_ratio_q;
assign loop_input_select   = src_q;
assign src_internal_sel    = src_int_q;
assign src_external_sel    = src_ext_q;
assign clock_irq           = irq_q;

endmodule // pcic_top
`default_nettype wire

// file: pcic_map.vh
// Register map and field constants for the PLL config and clock irq block
//
// Behaviour
// (R1) P code plus one divides VCO; zero reserved
// (R2) P, N, M, source writable only PLL off
// (R3) Bit 16 gates the P-divided clock output
// (R4) N is feedback ratio, 8 to 86 valid
// (R5) M code plus one divides PLL input
// (R6) Source: none, reserved, internal, external oscillator
// (R7) Software keeps VCO and output frequencies legal
// (R8) Five read-write ready interrupt enable bits
// (R9) Lock flag set on lock when enabled
// (R10) External fast ready flag set when enabled
// (R11) Internal fast flag only after software enable
// (R12) Slow oscillator ready flags set when enabled
// (R13) Slow external failure sets flag bit 9
// (R14) Fast external failure sets flag bit 8
// (R15) Writing one to clear bit clears flag
// (R16) Irq enable, flag, clear registers reset zero
// (R17) Software writes reserved bits as reset value
// (R18) Interrupt high while any flag is set
`ifndef PCIC_MAP_VH
`define PCIC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCIC_OFS_PLLCFG   8'h0C
`define PCIC_OFS_IRQEN    8'h18
`define PCIC_OFS_FLAGS    8'h1C
`define PCIC_OFS_CLEAR    8'h20

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PCIC_RST_PLLCFG   32'h00001000
`define PCIC_RST_IRQ      32'h00000000
`define PCIC_MSK_IRQEN    32'h0000003B
`define PCIC_MSK_FLAGS    32'h0000033B
`define PCIC_MSK_LOCKED   32'h003E7F73
`define PCIC_MSK_PEN      32'h00010000

// ----------------------------------------------------------------
// Field positions of the PLL configuration word
// ----------------------------------------------------------------
`define PCIC_P_MSB        21
`define PCIC_P_LSB        17
`define PCIC_PEN_BIT      16
`define PCIC_N_MSB        14
`define PCIC_N_LSB        8
`define PCIC_M_MSB        6
`define PCIC_M_LSB        4
`define PCIC_SRC_MSB      1
`define PCIC_SRC_LSB      0

// ----------------------------------------------------------------
// Codes and limits
// ----------------------------------------------------------------
`define PCIC_N_MIN        7'h08
`define PCIC_N_MAX        7'h56
`define PCIC_SRC_NONE     2'h0
`define PCIC_SRC_INT      2'h2
`define PCIC_SRC_EXT      2'h3

// ----------------------------------------------------------------
// Flag and enable bit positions
// ----------------------------------------------------------------
`define PCIC_B_ISLOW      0
`define PCIC_B_ESLOW      1
`define PCIC_B_IFAST      3
`define PCIC_B_EFAST      4
`define PCIC_B_LOCK       5
`define PCIC_B_EFAIL      8
`define PCIC_B_SFAIL      9

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define PCIC_RESP_OKAY    2'h0
`define PCIC_RESP_SLVERR  2'h2

`endif

// file: pcic_chk.sv
// Assertion checker for the PLL config and clock irq block
`timescale 1ns/1ns
`default_nettype none
module pcic_chk (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       pll_on,
	input wire logic [4:0] vco_div_p,
	input wire logic [5:0] p_divide_ratio,
	input wire logic       p_ratio_valid,
	input wire logic [6:0] feedback_multiplier,
	input wire logic       feedback_valid,
	input wire logic [3:0] input_divide_ratio,
	input wire logic [1:0] loop_input_select,
	input wire logic       src_internal_sel,
	input wire logic       src_external_sel,
	input wire logic       clock_irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Decoded outputs settle one edge after reset release; checks wait for two
	logic [1:0] up_q;
	always @(posedge aclk) up_q <= aresetn ? {up_q[0], 1'b1} : 2'b00;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_RATIO: assert property (up_q[1] |-> p_divide_ratio == {1'b0, vco_div_p} + 6'h01)
		else $error("P ratio is not code plus one");
	AST_PVALID: assert property (up_q[1] |-> p_ratio_valid == (vco_div_p != 5'h00))
		else $error("P valid flag wrong");
	AST_NVALID: assert property (up_q[1] |-> feedback_valid ==
		(feedback_multiplier >= 7'h08 && feedback_multiplier <= 7'h56))
		else $error("Feedback valid flag wrong");
	AST_SRC: assert property (up_q[1] |-> src_internal_sel == (loop_input_select == 2'h2)
		&& src_external_sel == (loop_input_select == 2'h3))
		else $error("Source select decode wrong");
	AST_MDIV: assert property (up_q[1] |-> input_divide_ratio >= 4'h1
		&& input_divide_ratio <= 4'h8)
		else $error("Input divide ratio out of range");
	AST_LOCK: assert property (pll_on [*3] |=> $stable(vco_div_p) && $stable(feedback_multiplier)
		&& $stable(input_divide_ratio) && $stable(loop_input_select))
		else $error("Locked field changed while PLL on");
	AST_IRQFALL: assert property ($fell(clock_irq) |-> $rose(s_axi_bvalid))
		else $error("Interrupt dropped without a write");
	AST_BLAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("Write response late");
	AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read data late");
	AST_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write channel ready during response");
	cover property (clock_irq);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (pll_on && s_axi_bvalid);
endmodule // pcic_chk

bind pcic_top pcic_chk u_pcic_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .pll_on, .vco_div_p, .p_divide_ratio, .p_ratio_valid,
	.feedback_multiplier, .feedback_valid, .input_divide_ratio, .loop_input_select,
	.src_internal_sel, .src_external_sel, .clock_irq);
`default_nettype wire

// file: pcic_top_test.sv
// Self-checking bench for the PLL config and clock irq block
`timescale 1ns/1ns
`default_nettype none
module pcic_top_test;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pll_on, osc_on;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [6:0]  st;
	logic [1:0]  rs;
	wire  [31:0] rdata;
	wire  [1:0]  bresp, rresp, src;
	wire  [4:0]  p;
	wire  [5:0]  pr;
	wire  [6:0]  n;
	wire  [3:0]  mr;
	wire         awready, wready, bvalid, arready, rvalid, pv, pen, nv, si, se, irq;
	wire  [31:0] outs = {3'h0, p, pr, pv, pen, n, nv, mr, src, si, se};
	logic [4:0]  tp [4] = '{5'h00, 5'h01, 5'h1F, 5'h10};
	logic [6:0]  tn [4] = '{7'h07, 7'h08, 7'h56, 7'h57};
	logic [2:0]  tm [4] = '{3'h0, 3'h1, 3'h7, 3'h3};
	int          n_fail, comparisons, i;

	pcic_top u_pcic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pll_on(pll_on), .internal_fast_osc_on(osc_on),
		.pll_locked(st[0]), .external_fast_osc_ready(st[1]),
		.internal_16mhz_osc_ready(st[2]), .external_slow_osc_ready(st[3]),
		.internal_slow_osc_ready(st[4]), .external_fast_osc_fail(st[5]),
		.external_slow_osc_fail(st[6]), .vco_div_p(p), .p_divide_ratio(pr),
		.p_ratio_valid(pv), .p_output_enable(pen), .feedback_multiplier(n),
		.feedback_valid(nv), .input_divide_ratio(mr), .loop_input_select(src),
		.src_internal_sel(si), .src_external_sel(se), .clock_irq(irq));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ----------------------------------------
	// Report, compare and bus tasks
	// ----------------------------------------
	task automatic final_report;
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		comparisons++;
		if (got !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, e);
		end
	endtask

	// Response stays pending until the edge that sees bvalid with bready high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rs = bresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rs = rresp;
		chk(rdata, e);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, pll_on, osc_on} = 8'h00;
		{awaddr, araddr, wdata, st} = 55'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(8'h18, 32'h00000000);
		rchk(8'h1C, 32'h00000000);
		rchk(8'h20, 32'h00000000);
		rchk(8'h0C, 32'h00001000);
		chk({31'h0, irq}, 32'h0);
		wr(8'h18, 32'h0000003B);
		chk({30'h0, rs}, 32'h0);
		rchk(8'h18, 32'h0000003B);
		wr(8'h04, 32'hFFFFFFFF);
		chk({30'h0, rs}, 32'h2);
		rchk(8'h04, 32'h0);
		chk({30'h0, rs}, 32'h2);
		for (i = 0; i < 4; i++) begin
			wr(8'h0C, {10'h0, tp[i], i[0], 1'b0, tn[i], 1'b0, tm[i], 2'h0, i[1:0]});
			@(posedge aclk);
			chk(outs, {3'h0, tp[i], {1'b0, tp[i]} + 6'h01, tp[i] != 5'h00, i[0], tn[i],
				tn[i] >= 7'h08 && tn[i] <= 7'h56, {1'b0, tm[i]} + 4'h1, i[1:0],
				i[1:0] == 2'h2, i[1:0] == 2'h3});
		end
		pll_on <= 1'b1;
		wr(8'h0C, 32'h0);
		rchk(8'h0C, 32'h00205733);
		pll_on <= 1'b0;
		wr(8'h18, 32'h0);
		osc_on <= 1'b1;
		st <= 7'h7F;
		repeat (8) @(posedge aclk);
		rchk(8'h1C, 32'h00000300);
		chk({31'h0, irq}, 32'h1);
		wr(8'h20, 32'h00000300);
		rchk(8'h1C, 32'h0);
		st <= 7'h00;
		osc_on <= 1'b0;
		wr(8'h18, 32'h0000003B);
		st <= 7'h7F;
		repeat (8) @(posedge aclk);
		rchk(8'h1C, 32'h00000333);
		st <= 7'h7B;
		osc_on <= 1'b1;
		repeat (8) @(posedge aclk);
		st <= 7'h7F;
		repeat (8) @(posedge aclk);
		rchk(8'h1C, 32'h0000033B);
		wr(8'h20, 32'h0);
		wr(8'h1C, 32'h0);
		rchk(8'h1C, 32'h0000033B);
		wr(8'h20, 32'h00000200);
		rchk(8'h1C, 32'h0000013B);
		chk({31'h0, irq}, 32'h1);
		wr(8'h20, 32'h0000033B);
		rchk(8'h1C, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rchk(8'h20, 32'h0);
		wr(8'h0C, 32'h00030802);
		rchk(8'h0C, 32'h00030802);
		chk(outs, {3'h0, 5'h01, 6'h02, 1'b1, 1'b1, 7'h08, 1'b1, 4'h1, 2'h2, 1'b1, 1'b0});
		final_report();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		n_fail++;
		final_report();
	end
endmodule // pcic_top_test
`default_nettype wire
